// >>> inc/flash_pin_pkg.sv
// shared constants and types for the serial flash pin interface
package flash_pin_pkg;

	localparam int          BYTE_W        = 8;      // bits per serial byte
	localparam int          RX_FIFO_DEPTH = 8;      // received-byte buffer depth
	localparam int          SYNC_W        = 5;      // pins passed through the synchroniser
	localparam int          SYNC_CS_POS   = 0;      // chip select (active low) position in sync bus
	localparam int          SYNC_SCK_POS  = 1;      // serial clock position
	localparam int          SYNC_SI_POS   = 2;      // input lane position
	localparam int          SYNC_HOLD_POS = 3;      // hold (active low) position
	localparam int          SYNC_WP_POS   = 4;      // write protect (active low) position
	localparam logic [4:0]  SYNC_RST_VAL  = 5'h19;  // cs, hold, wp idle high; sck, si low
	localparam logic [3:0]  BIT_CNT_FULL  = 4'h8;   // bits in one byte, as a count
	localparam logic [3:0]  BIT_CNT_RST   = 4'h0;   // bit counter reset value
	localparam logic [7:0]  TX_IDLE_BYTE  = 8'hff;  // shifted out when no byte is waiting
	localparam logic [7:0]  BYTE_RST      = 8'h00;  // data register reset value

	// link states seen from the device side
	typedef enum logic [1:0] {
		LS_DESELECTED,
		LS_ACTIVE,
		LS_HOLD
	} link_state_e;

endpackage

// >>> logic/pin_sync.sv
// two-flop synchroniser bank for pins arriving from outside the core clock
`timescale 1ns/1ps
module pin_sync #(
	parameter int               W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic           i_core_clk,
	input  wire logic           i_rst_b,
	input  wire logic [W-1:0]   i_async,
	output logic      [W-1:0]   o_sync
);

	logic [W-1:0] meta_ff;      // first stage, read only by the second stage
	logic [W-1:0] sync_ff;      // second stage, safe to use
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	// next values: plain shift through the two stages
	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
	end

	// reset to the idle level of each pin so no false edge appears at release
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign o_sync = sync_ff;

endmodule

// >>> logic/byte_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_in_data,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	output logic      [W-1:0] o_out_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [W-1:0]     mem_ff [DEPTH];     // storage words
	logic [W-1:0]     nxt_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;          // next slot to fill
	logic [PTR_W-1:0] rd_ptr_ff;          // oldest slot
	logic [CNT_W-1:0] count_ff;           // words held
	logic [PTR_W-1:0] nxt_wr_ptr;
	logic [PTR_W-1:0] nxt_rd_ptr;
	logic [CNT_W-1:0] nxt_count;
	logic             push;
	logic             pop;

	// pointer wrap shared by both sides
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
	endfunction

	// honest full and empty straight from the count
	assign o_in_ready  = (count_ff != CNT_W'(DEPTH));
	assign o_out_valid = (count_ff != '0);
	assign o_out_data  = mem_ff[rd_ptr_ff];

	// next values for storage and pointers
	always_comb begin
		push       = i_in_valid && o_in_ready;
		pop        = o_out_valid && i_out_ready;
		nxt_mem    = mem_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count  = count_ff;
		if (push) begin
			nxt_mem[wr_ptr_ff] = i_in_data;
			nxt_wr_ptr         = ptr_inc(wr_ptr_ff);
		end
		if (pop) begin
			nxt_rd_ptr = ptr_inc(rd_ptr_ff);
		end
		if (push && !pop) begin
			nxt_count = CNT_W'(count_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_count = CNT_W'(count_ff - 1'b1);
		end
	end

	// register only
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			mem_ff    <= nxt_mem;
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
		end
	end

endmodule

// >>> logic/flash_pin_if.sv
// device-side pin interface of a serial flash: framing, shifting, dual output, hold, write protect
//
// Notes on behaviour
// - chip select high: deselect, standby, float output
// - deselected: input lane ignored entirely
// - operations framed by chip select edges
// - self-timed cycle delays standby after deselect
// - input lane captured on rising clock edges
// - output lanes change only on falling edges
// - dual read drives both lanes, two bits
// - active-low write protect gates hardware locking
// - write protect pulled up, inactive when open
// - hold pauses transfer, keeps command state
// - during hold: ignore clock, data; float output
// - hold never affects self-timed cycle
// - hold pulled up, inactive when open
`timescale 1ns/1ps
module flash_pin_if
	import flash_pin_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_b,
	// pins from the host
	input  wire logic              i_cs_b,
	input  wire logic              i_sck,
	input  wire logic              i_dual_lane_zero_in,
	output logic                   o_dual_lane_zero_out,
	output logic                   o_dual_lane_zero_oe,
	output logic                   o_dual_lane_one_out,
	output logic                   o_dual_lane_one_oe,
	input  wire logic              i_wp_b,
	input  wire logic              i_hold_b,
	// core side: received bytes
	output logic      [BYTE_W-1:0] o_rx_data,
	output logic                   o_rx_valid,
	input  wire logic              i_rx_ready,
	output logic                   o_rx_overrun,
	// core side: bytes to send
	input  wire logic [BYTE_W-1:0] i_tx_data,
	input  wire logic              i_tx_valid,
	output logic                   o_tx_ready,
	input  wire logic              i_read_phase,
	input  wire logic              i_dual_phase,
	// core side: framing and status
	input  wire logic              i_busy,
	output logic                   o_selected,
	output logic                   o_frame_start,
	output logic                   o_frame_end,
	output logic                   o_hold_active,
	output logic                   o_standby,
	output logic                   o_hw_lock
);

	logic [SYNC_W-1:0] pins_s;        // synchronised pin levels
	logic              cs_b_s;
	logic              sck_s;
	logic              si_s;
	logic              hold_b_s;
	logic              wp_b_s;

	link_state_e       state_ff;      // link state
	link_state_e       nxt_state;
	logic              sck_d_ff;      // last synchronised clock level
	logic              cs_b_d_ff;     // last synchronised chip select level
	logic              nxt_sck_d;
	logic              nxt_cs_b_d;
	logic              rise_seen_ff;  // a rising edge has come in this frame
	logic              nxt_rise_seen;
	logic [BYTE_W-1:0] rx_shift_ff;   // incoming bits, msb first
	logic [BYTE_W-1:0] nxt_rx_shift;
	logic [3:0]        rx_cnt_ff;     // bits gathered so far
	logic [3:0]        nxt_rx_cnt;
	logic [BYTE_W-1:0] tx_shift_ff;   // outgoing bits, msb first
	logic [BYTE_W-1:0] nxt_tx_shift;
	logic [3:0]        tx_cnt_ff;     // bits still to send from tx_shift_ff
	logic [3:0]        nxt_tx_cnt;
	logic [BYTE_W-1:0] hold_byte_ff;  // next byte waiting for the shifter
	logic [BYTE_W-1:0] nxt_hold_byte;
	logic              hold_full_ff;
	logic              nxt_hold_full;
	logic              tx_ready_ff;
	logic              nxt_tx_ready;
	logic              lane0_out_ff;
	logic              lane0_oe_ff;
	logic              lane1_out_ff;
	logic              lane1_oe_ff;
	logic              nxt_lane0_out;
	logic              nxt_lane0_oe;
	logic              nxt_lane1_out;
	logic              nxt_lane1_oe;
	logic              selected_ff;
	logic              frame_start_ff;
	logic              frame_end_ff;
	logic              hold_act_ff;
	logic              standby_ff;
	logic              hw_lock_ff;
	logic              overrun_ff;
	logic              nxt_overrun;
	logic              fifo_push;     // completed byte offered to the fifo
	logic              fifo_in_ready; // fifo has room
	logic [BYTE_W-1:0] push_byte;
	logic              sck_rise;
	logic              sck_fall;
	logic              cs_fall;
	logic [BYTE_W-1:0] cur_byte;      // byte being driven this falling edge
	logic [3:0]        cur_cnt;

	// edge finder, used on clock and chip select
	function automatic logic edge_of(input logic prev, input logic cur, input logic rising);
		edge_of = rising ? (!prev && cur) : (prev && !cur);
	endfunction

	// every pin from the host passes two flops before any logic reads it
	pin_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST_VAL)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    ({i_wp_b, i_hold_b, i_dual_lane_zero_in, i_sck, i_cs_b}),
		.o_sync     (pins_s)
	);

	assign cs_b_s   = pins_s[SYNC_CS_POS];
	assign sck_s    = pins_s[SYNC_SCK_POS];
	assign si_s     = pins_s[SYNC_SI_POS];
	assign hold_b_s = pins_s[SYNC_HOLD_POS];
	assign wp_b_s   = pins_s[SYNC_WP_POS];

	assign sck_rise = edge_of(sck_d_ff, sck_s, 1'b1);
	assign sck_fall = edge_of(sck_d_ff, sck_s, 1'b0);
	assign cs_fall  = edge_of(cs_b_d_ff, cs_b_s, 1'b0);

	// received bytes wait here; the core drains them at its own pace
	byte_fifo #(
		.W     (BYTE_W),
		.DEPTH (RX_FIFO_DEPTH)
	) u_rx_fifo (
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_in_data   (push_byte),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.o_out_data  (o_rx_data),
		.o_out_valid (o_rx_valid),
		.i_out_ready (i_rx_ready)
	);

	// next values for the whole link: framing, hold, both shifters and the lanes
	always_comb begin
		nxt_state     = state_ff;
		nxt_sck_d     = sck_s;
		nxt_cs_b_d    = cs_b_s;
		nxt_rise_seen = rise_seen_ff;
		nxt_rx_shift  = rx_shift_ff;
		nxt_rx_cnt    = rx_cnt_ff;
		nxt_tx_shift  = tx_shift_ff;
		nxt_tx_cnt    = tx_cnt_ff;
		nxt_hold_byte = hold_byte_ff;
		nxt_hold_full = hold_full_ff;
		nxt_lane0_out = lane0_out_ff;
		nxt_lane0_oe  = lane0_oe_ff;
		nxt_lane1_out = lane1_out_ff;
		nxt_lane1_oe  = lane1_oe_ff;
		nxt_overrun   = overrun_ff;
		fifo_push     = 1'b0;
		push_byte     = {rx_shift_ff[BYTE_W-2:0], si_s};
		cur_byte      = tx_shift_ff;
		cur_cnt       = tx_cnt_ff;
		case (state_ff)
			LS_DESELECTED: begin
				// input lane and clock ignored until a new frame opens
				nxt_lane0_oe = 1'b0;
				nxt_lane1_oe = 1'b0;
				if (cs_fall) begin
					nxt_state     = LS_ACTIVE;
					nxt_rise_seen = 1'b0;
					nxt_rx_cnt    = BIT_CNT_RST;
					nxt_tx_cnt    = BIT_CNT_RST;
					nxt_overrun   = 1'b0;
				end
			end
			LS_ACTIVE: begin
				if (cs_b_s) begin
					// partial bytes are dropped: the frame is over
					nxt_state    = LS_DESELECTED;
					nxt_lane0_oe = 1'b0;
					nxt_lane1_oe = 1'b0;
				end else if (!hold_b_s && !sck_s) begin
					// counters and shifters stay as they are for the resume
					nxt_state    = LS_HOLD;
					nxt_lane0_oe = 1'b0;
					nxt_lane1_oe = 1'b0;
				end else begin
					if (sck_rise) begin
						// mode 3 idles high, so its first falling edge comes before any rise
						nxt_rise_seen = 1'b1;
						if (!(i_read_phase && i_dual_phase)) begin
							// lane zero is an output in dual reads, nothing to capture
							nxt_rx_shift = push_byte;
							nxt_rx_cnt   = 4'(rx_cnt_ff + 1'b1);
							if (4'(rx_cnt_ff + 1'b1) == BIT_CNT_FULL) begin
								nxt_rx_cnt = BIT_CNT_RST;
								fifo_push  = fifo_in_ready;
								// the host cannot be stalled; a full buffer loses the byte
								nxt_overrun = overrun_ff || !fifo_in_ready;
							end
						end
					end
					if (sck_fall && rise_seen_ff) begin
						if (i_read_phase) begin
							if (tx_cnt_ff == BIT_CNT_RST) begin
								cur_byte      = hold_full_ff ? hold_byte_ff : TX_IDLE_BYTE;
								cur_cnt       = BIT_CNT_FULL;
								nxt_hold_full = 1'b0;
							end
							if (i_dual_phase) begin
								// two bits per edge, odd bit on lane one
								nxt_lane1_out = cur_byte[BYTE_W-1];
								nxt_lane0_out = cur_byte[BYTE_W-2];
								nxt_lane1_oe  = 1'b1;
								nxt_lane0_oe  = 1'b1;
								nxt_tx_shift  = {cur_byte[BYTE_W-3:0], 2'b00};
								nxt_tx_cnt    = 4'(cur_cnt - 4'h2);
							end else begin
								nxt_lane1_out = cur_byte[BYTE_W-1];
								nxt_lane1_oe  = 1'b1;
								nxt_lane0_oe  = 1'b0;
								nxt_tx_shift  = {cur_byte[BYTE_W-2:0], 1'b0};
								nxt_tx_cnt    = 4'(cur_cnt - 4'h1);
							end
						end else begin
							// read phase over: release both lanes on this edge
							nxt_lane0_oe = 1'b0;
							nxt_lane1_oe = 1'b0;
						end
					end
				end
			end
			LS_HOLD: begin
				// clock and lane zero are not looked at here
				nxt_lane0_oe = 1'b0;
				nxt_lane1_oe = 1'b0;
				if (cs_b_s) begin
					nxt_state = LS_DESELECTED;
				end else if (hold_b_s) begin
					// restore the lanes only at the next falling edge
					nxt_state = LS_ACTIVE;
				end
			end
			default: begin
				nxt_state    = LS_DESELECTED;
				nxt_lane0_oe = 1'b0;
				nxt_lane1_oe = 1'b0;
			end
		endcase
		// core hands over the next byte while the holding slot is free
		if (i_tx_valid && tx_ready_ff) begin
			nxt_hold_byte = i_tx_data;
			nxt_hold_full = 1'b1;
		end
		nxt_tx_ready = !nxt_hold_full;
	end

	// link state registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_ff     <= LS_DESELECTED;
			sck_d_ff     <= 1'b0;
			cs_b_d_ff    <= 1'b1;
			rise_seen_ff <= 1'b0;
			rx_shift_ff  <= BYTE_RST;
			rx_cnt_ff    <= BIT_CNT_RST;
			tx_shift_ff  <= BYTE_RST;
			tx_cnt_ff    <= BIT_CNT_RST;
			hold_byte_ff <= BYTE_RST;
			hold_full_ff <= 1'b0;
			tx_ready_ff  <= 1'b0;
			lane0_out_ff <= 1'b0;
			lane0_oe_ff  <= 1'b0;
			lane1_out_ff <= 1'b0;
			lane1_oe_ff  <= 1'b0;
			overrun_ff   <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			sck_d_ff     <= nxt_sck_d;
			cs_b_d_ff    <= nxt_cs_b_d;
			rise_seen_ff <= nxt_rise_seen;
			rx_shift_ff  <= nxt_rx_shift;
			rx_cnt_ff    <= nxt_rx_cnt;
			tx_shift_ff  <= nxt_tx_shift;
			tx_cnt_ff    <= nxt_tx_cnt;
			hold_byte_ff <= nxt_hold_byte;
			hold_full_ff <= nxt_hold_full;
			tx_ready_ff  <= nxt_tx_ready;
			lane0_out_ff <= nxt_lane0_out;
			lane0_oe_ff  <= nxt_lane0_oe;
			lane1_out_ff <= nxt_lane1_out;
			lane1_oe_ff  <= nxt_lane1_oe;
			overrun_ff   <= nxt_overrun;
		end
	end

	// status flags, registered so each output comes from a flop
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			selected_ff    <= 1'b0;
			frame_start_ff <= 1'b0;
			frame_end_ff   <= 1'b0;
			hold_act_ff    <= 1'b0;
			standby_ff     <= 1'b1;
			hw_lock_ff     <= 1'b0;
		end else begin
			selected_ff    <= (nxt_state != LS_DESELECTED);
			frame_start_ff <= (state_ff == LS_DESELECTED) && (nxt_state == LS_ACTIVE);
			frame_end_ff   <= (state_ff != LS_DESELECTED) && (nxt_state == LS_DESELECTED);
			hold_act_ff    <= (nxt_state == LS_HOLD);
			// a running program or erase keeps the part out of standby, hold or not
			standby_ff     <= (nxt_state == LS_DESELECTED) && !i_busy;
			// a floating pin reads high through its pull-up: locking off
			hw_lock_ff     <= !wp_b_s;
		end
	end

	assign o_dual_lane_zero_out = lane0_out_ff;
	assign o_dual_lane_zero_oe  = lane0_oe_ff;
	assign o_dual_lane_one_out  = lane1_out_ff;
	assign o_dual_lane_one_oe   = lane1_oe_ff;
	assign o_tx_ready           = tx_ready_ff;
	assign o_rx_overrun         = overrun_ff;
	assign o_selected           = selected_ff;
	assign o_frame_start        = frame_start_ff;
	assign o_frame_end          = frame_end_ff;
	assign o_hold_active        = hold_act_ff;
	assign o_standby            = standby_ff;
	assign o_hw_lock            = hw_lock_ff;

endmodule

// >>> verification/flash_pin_assertions.sv
// port timing checker for the flash pin interface
`timescale 1ns/1ps
module flash_pin_chk (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_cs_b,
	input wire logic i_sck,
	input wire logic i_wp_b,
	input wire logic i_hold_b,
	input wire logic i_busy,
	input wire logic o_dual_lane_zero_oe,
	input wire logic o_dual_lane_one_out,
	input wire logic o_dual_lane_one_oe,
	input wire logic o_rx_valid,
	input wire logic o_selected,
	input wire logic o_frame_start,
	input wire logic o_frame_end,
	input wire logic o_hold_active,
	input wire logic o_standby,
	input wire logic o_hw_lock
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// pins cross two sync flops plus one register, so margins of a few cycles
	sequence s_desel_long;
		i_cs_b[*6];
	endsequence
	sequence s_idle_gap;
		(!o_selected && !i_busy)[*2] ##1 !o_selected;
	endsequence
	sequence s_sck_low_seen;
		!$past(i_sck) && !$past(i_sck, 2);
	endsequence
	AST_DESEL_FLOAT: assert property (s_desel_long |-> !o_dual_lane_one_oe && !o_dual_lane_zero_oe)
		else $error("lane driven while deselected");
	AST_STANDBY_IDLE: assert property (s_idle_gap |-> o_standby)
		else $error("no standby while idle");
	AST_BUSY_STANDBY: assert property (i_busy |=> !o_standby)
		else $error("standby during busy");
	AST_WP_LOCK: assert property (!i_wp_b[*5] |-> o_hw_lock)
		else $error("lock not engaged");
	AST_LANE_EDGE: assert property ($changed(o_dual_lane_one_out) && o_dual_lane_one_oe && $past(o_dual_lane_one_oe)
		|-> s_sck_low_seen)
		else $error("lane changed off a falling clock");
	AST_HOLD_FLOAT: assert property (o_hold_active && $past(o_hold_active) |-> !o_dual_lane_one_oe)
		else $error("lane driven in hold");
	AST_HOLD_START: assert property ($rose(o_hold_active) |-> !$past(i_hold_b, 3) && !$past(i_sck, 3)
		&& $past(o_selected))
		else $error("hold began out of order");
	AST_HOLD_SELECTED: assert property (o_hold_active |-> o_selected)
		else $error("hold deselected the device");
	AST_FRAME_START: assert property ($fell(i_cs_b) |-> ##[2:6] o_frame_start ##1 !o_frame_start)
		else $error("frame start missing");
	AST_RX_SELECTED: assert property ($rose(o_rx_valid) |-> $past(o_selected))
		else $error("byte taken while deselected");
	AST_FRAME_END: assert property ($rose(i_cs_b) |-> ##[2:6] o_frame_end ##1 !o_frame_end)
		else $error("frame end missing");
endmodule
bind flash_pin_if flash_pin_chk u_flash_pin_chk (.i_core_clk, .i_rst_b, .i_cs_b, .i_sck, .i_wp_b, .i_hold_b,
	.i_busy, .o_dual_lane_zero_oe, .o_dual_lane_one_out, .o_dual_lane_one_oe, .o_rx_valid, .o_selected,
	.o_frame_start, .o_frame_end, .o_hold_active, .o_standby, .o_hw_lock);

// >>> verification/flash_host_model.sv
// behavioural spi host driving the flash pins
`timescale 1ns/1ps
module flash_host_model (
	input  wire logic i_core_clk,
	input  wire logic i_lane_zero,
	input  wire logic i_lane_one,
	output logic      o_cs_b,
	output logic      o_sck,
	output logic      o_si,
	output logic      o_si_oe,
	output logic      o_hold_b
);
	logic idle_sck; // clock level between frames
	initial begin
		{o_cs_b, o_sck, o_si, o_si_oe, o_hold_b, idle_sck} = 6'h2b;
	end
	// pins only move on falling core edges
	task automatic tk(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	// clock parked low or high before select falls
	task automatic open_frame(input logic mode3);
		idle_sck = mode3;
		o_sck = mode3;
		tk(4);
		o_cs_b = 1'b0;
		tk(4);
	endtask
	// lane zero is taken back only once deselected, never against the device
	task automatic close_frame();
		o_sck = idle_sck;
		tk(4);
		o_cs_b = 1'b1;
		tk(8);
		o_si_oe = 1'b1;
	endtask
	// toggling with select high must be ignored
	task automatic noise();
		repeat (16) begin
			o_sck = !o_sck;
			o_si = !o_si;
			tk(4);
		end
	endtask
	// one byte msb first; data set with clock low, lane one (and lane zero in dual) read at the rise
	task automatic xfer(input logic [7:0] tx, input logic dual, input int hold_at, output logic [7:0] rx);
		int n;
		n = dual ? 4 : 8;
		o_si_oe = !dual;
		for (int i = 0; i < n; i++) begin
			o_sck = 1'b0;
			o_si = tx[7-i];
			tk(4);
			if (i == hold_at) begin
				o_hold_b = 1'b0;
				tk(6);
				o_sck = 1'b1;
				o_si = !o_si;
				tk(4);
				o_sck = 1'b0;
				tk(4);
				o_hold_b = 1'b1;
				o_si = tx[7-i];
				tk(6);
			end
			if (dual) begin
				rx[7-2*i] = i_lane_one;
				rx[6-2*i] = i_lane_zero;
			end else begin
				rx[7-i] = i_lane_one;
			end
			o_sck = 1'b1;
			tk(4);
		end
	endtask
endmodule

// >>> verification/tb_flash_pin_if.sv
// self-checking bench for the flash pin interface
`timescale 1ns/1ps
module tb_flash_pin_if;
	import flash_pin_pkg::*;
	logic              clk, rst_b, junk, wp_en, wp_val, cs_b, sck, si, si_oe, hold_b;
	logic              lz_out, lz_oe, lo_out, lo_oe, rx_valid, rx_ready, overrun, tx_ready, tx_valid;
	logic              read_ph, dual_ph, busy, selected, fstart, fend, hold_act, standby, hw_lock;
	logic [BYTE_W-1:0] rx_data, tx_data, r, a, b;
	logic [31:0]       seed;
	logic [7:0]        exp_q[$];
	int                num_errors, samples_checked;
	wire               lane_zero = lz_oe ? lz_out : (si_oe ? si : junk); // released lane wanders
	wire               lane_one  = lo_oe ? lo_out : junk;
	wire               wp_b      = wp_en ? wp_val : 1'b1; // pad pull-up
	flash_host_model u_flash_host_model (.i_core_clk(clk), .i_lane_zero(lane_zero), .i_lane_one(lane_one),
		.o_cs_b(cs_b), .o_sck(sck), .o_si(si), .o_si_oe(si_oe), .o_hold_b(hold_b));
	flash_pin_if u_flash_pin_if (.i_core_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sck(sck),
		.i_dual_lane_zero_in(lane_zero), .o_dual_lane_zero_out(lz_out), .o_dual_lane_zero_oe(lz_oe),
		.o_dual_lane_one_out(lo_out), .o_dual_lane_one_oe(lo_oe), .i_wp_b(wp_b), .i_hold_b(hold_b),
		.o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_overrun(overrun),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_read_phase(read_ph),
		.i_dual_phase(dual_ph), .i_busy(busy), .o_selected(selected), .o_frame_start(fstart),
		.o_frame_end(fend), .o_hold_active(hold_act), .o_standby(standby), .o_hw_lock(hw_lock));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) junk <= ~junk;
	// xorshift source for every data byte
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic tk(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask
	// byte noted before it is sent, unless it should be dropped
	task automatic wr(input int h, input logic keep);
		logic [7:0] x;
		x = rnd();
		if (keep) exp_q.push_back(x);
		u_flash_host_model.xfer(x, 1'b0, h, r);
	endtask
	// a dual phase ignores lane zero, so nothing is noted then
	task automatic rd(input logic dual, input logic [7:0] e);
		logic [7:0] x;
		x = rnd();
		if (!dual) exp_q.push_back(x);
		u_flash_host_model.xfer(x, dual, -1, r);
		chk_byte("lane_data", e, r);
	endtask
	// valid held until the edge where ready is seen
	task automatic offer(input logic [7:0] v);
		int n;
		tx_data = v;
		tx_valid = 1'b1;
		for (n = 0; n < 400 && tx_ready !== 1'b1; n++) @(negedge clk);
		// a slot that never frees counts as a mismatch here
		chk_bit("tx_ready", 1'b1, tx_ready);
		@(negedge clk);
		tx_valid = 1'b0;
		// one idle cycle so a following offer never re-raises valid in this step
		@(negedge clk);
	endtask
	task automatic done(input string nm);
		$display("test %0s finished", nm);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// each popped byte is compared with the oldest note
	always @(posedge clk) begin
		if (rst_b === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
			chk_byte("rx_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_data);
		end
	end
	initial begin
		{rst_b, junk, wp_en, wp_val, rx_ready, tx_valid, read_ph, dual_ph, busy} = '0;
		tx_data = '0;
		seed = 32'h6b6f;
		num_errors = 0;
		samples_checked = 0;
		tk(2);
		rst_b = 1'b1;
		rx_ready = 1'b1;
		tk(4);
		u_flash_host_model.open_frame(1'b0);
		repeat (3) wr(-1, 1'b1);
		u_flash_host_model.close_frame();
		done("write");
		u_flash_host_model.noise();
		tk(8);
		chk_bit("rx_valid", 1'b0, rx_valid);
		done("deselected");
		rx_ready = 1'b0;
		u_flash_host_model.open_frame(1'b0);
		repeat (RX_FIFO_DEPTH) wr(-1, 1'b1);
		wr(-1, 1'b0);
		u_flash_host_model.close_frame();
		chk_bit("overrun", 1'b1, overrun);
		// random back-pressure while the buffer drains
		repeat (24) begin
			a = rnd();
			rx_ready = a[0];
			tk(1);
		end
		rx_ready = 1'b1;
		tk(20);
		chk_bit("rx_valid", 1'b0, rx_valid);
		done("fifo");
		u_flash_host_model.open_frame(1'b1);
		tk(4);
		chk_bit("overrun", 1'b0, overrun);
		repeat (2) wr(-1, 1'b1);
		u_flash_host_model.close_frame();
		done("mode3");
		u_flash_host_model.open_frame(1'b0);
		wr(3, 1'b1);
		wr(-1, 1'b1);
		u_flash_host_model.close_frame();
		done("hold");
		a = rnd();
		b = rnd();
		fork
			begin
				offer(a);
				offer(b);
			end
			begin
				u_flash_host_model.open_frame(1'b0);
				wr(-1, 1'b1);
				read_ph = 1'b1;
				rd(1'b0, a);
				rd(1'b0, b);
				u_flash_host_model.close_frame();
			end
		join
		read_ph = 1'b0;
		done("read");
		a = rnd();
		offer(a);
		u_flash_host_model.open_frame(1'b0);
		wr(-1, 1'b1);
		read_ph = 1'b1;
		dual_ph = 1'b1;
		rd(1'b1, a);
		u_flash_host_model.close_frame();
		read_ph = 1'b0;
		dual_ph = 1'b0;
		done("dual");
		busy = 1'b1;
		u_flash_host_model.open_frame(1'b0);
		u_flash_host_model.close_frame();
		chk_bit("standby", 1'b0, standby);
		busy = 1'b0;
		tk(4);
		chk_bit("standby", 1'b1, standby);
		done("busy");
		wp_en = 1'b1;
		wp_val = 1'b0;
		tk(6);
		chk_bit("hw_lock", 1'b1, hw_lock);
		// random protect level: lock follows the inverted pin
		a = rnd();
		wp_val = a[0];
		tk(6);
		chk_bit("hw_lock", ~a[0], hw_lock);
		wp_en = 1'b0;
		tk(6);
		chk_bit("hw_lock", 1'b0, hw_lock);
		chk_byte("rx_left", 8'h00, 8'(exp_q.size()));
		done("protect");
		print_verdict();
	end
	// the run needs some 1600 core clocks
	initial begin
		#400us;
		num_errors++;
		print_verdict();
	end
endmodule
